// *** rtl/io_pad_group_map.svh ***
// Purpose: index, width and reset constants of the pad group mux
// Assumes: included by bare name from the package and the design modules
// Notes:   peripheral signals travel as two flat vectors, one per direction
`ifndef IO_PAD_GROUP_MAP_SVH
`define IO_PAD_GROUP_MAP_SVH

`define NUM_PADS        44
`define PAD_IDX_W       6
`define SEL_W           5
`define IDX_W           7
`define PADS_32PIN      6'd12
`define PADS_48PIN      6'd28
`define PADS_64PIN      6'd44
`define PKG_32PIN       2'h0
`define PKG_48PIN       2'h1
`define PKG_64PIN       2'h2
`define DIR_IN          1'b0
`define DIR_OUT         1'b1
`define GROUP_W         2
`define HALF_STEP       3'd4
`define GPIO_SKIP_POS   5'd3
`define GPIO_FULL_CNT   5'd10
`define GPIO_SHORT_CNT  5'd9

// peripheral outputs (towards pads)
`define POUT_W          72
`define PWM_BASE        7'd40
`define PAR_OUT_BASE    7'd48
`define O_DBG           7'd56
`define O_SER_TX        7'd57
`define O_SER_TRDY_N    7'd58
`define O_SER_DRV_EN    7'd59
`define O_PAR_RXAV_N    7'd60
`define O_HOST_SCLK     7'd61
`define O_HOST_SEL1_N   7'd62
`define O_PAR_TXSP_N    7'd63
`define O_SLV0_DIN      7'd64
`define O_SLV1_DIN      7'd65
`define O_HOST_DOUT     7'd66
`define O_PAR_SYNC_CLK  7'd67
`define O_SER_RTS_N     7'd68
`define O_SLV0_DOUT     7'd69
`define O_SLV1_DOUT     7'd70
`define O_HOST_SEL0_N   7'd71

// peripheral inputs (from pads)
`define PIN_W           64
`define PAR_IN_BASE     7'd40
`define I_DBG           7'd48
`define I_PAR_OE_N      7'd49
`define I_SLV0_SCLK     7'd50
`define I_SLV1_SCLK     7'd51
`define I_SER_RX        7'd52
`define I_SER_SRDY_N    7'd53
`define I_SLV0_DIN      7'd54
`define I_SLV1_DIN      7'd55
`define I_SER_CARR_N    7'd56
`define I_PAR_RD_N      7'd57
`define I_HOST_DIN      7'd58
`define I_SER_CTS_N     7'd59
`define I_SER_RING_N    7'd60
`define I_PAR_WR_N      7'd61
`define I_SLV0_SEL_N    7'd62
`define I_SLV1_SEL_N    7'd63
// idle level of every peripheral input: active-low ones sit high
`define PIN_IDLE        64'hfb22_0000_0000_0000

`endif

// *** rtl/io_pad_group_pkg.sv ***
// Purpose: types and the package strap decode of the pad group mux
// Assumes: io_pad_group_map.svh supplies all indices
// Notes:   pad p belongs to group p mod 4
`include "io_pad_group_map.svh"
`default_nettype none
package io_pad_group_pkg;

    typedef struct packed {
        logic                en;
        logic                dir;
        logic [`SEL_W-1:0]   sel;
    } pad_cfg_s;

    typedef struct packed {
        logic                ok;
        logic [`IDX_W-1:0]   idx;
    } route_s;

    localparam pad_cfg_s PAD_CFG_RESET = '0;

    function automatic logic [`PAD_IDX_W-1:0] pads_for_pkg(input logic [1:0] pkg);
        unique case (pkg)
            `PKG_32PIN: return `PADS_32PIN;
            `PKG_48PIN: return `PADS_48PIN;
            default:    return `PADS_64PIN;
        endcase
    endfunction

endpackage
`default_nettype wire

// *** rtl/pad_cfg_if.sv ***
// Purpose: carries pad configuration between the mux and its store
// Assumes: one clock, writes already checked by the controller
// Notes:   whole table is visible in parallel, readback is registered
`include "io_pad_group_map.svh"
`default_nettype none
interface pad_cfg_if;
    import io_pad_group_pkg::*;
    logic                  wr;
    logic [`PAD_IDX_W-1:0] wr_pad;
    pad_cfg_s              wr_data;
    logic [`PAD_IDX_W-1:0] rd_pad;
    pad_cfg_s              rd_data;
    pad_cfg_s              table_q [`NUM_PADS];

    modport ctrl  (output wr, wr_pad, wr_data, rd_pad, input rd_data, table_q);
    modport store (input wr, wr_pad, wr_data, rd_pad, output rd_data, table_q);
endinterface
`default_nettype wire

// *** rtl/pad_cfg_store.sv ***
// Purpose: holds one routing entry per pad
// Assumes: wr_pad is below the pad count
// Notes:   readback data leave through a register, one cycle after rd_pad
`include "io_pad_group_map.svh"
`default_nettype none
module pad_cfg_store
    import io_pad_group_pkg::*;
(
    input  wire logic     clk_sys_in,
    input  wire logic     reset_n_in,
    pad_cfg_if.store      cfg
);
    pad_cfg_s entry_r [`NUM_PADS];
    pad_cfg_s rd_r;

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int p = 0; p < `NUM_PADS; p++)
                entry_r[p] <= PAD_CFG_RESET;
            rd_r <= PAD_CFG_RESET;
        end else begin
            if (cfg.wr)
                entry_r[cfg.wr_pad] <= cfg.wr_data;
            rd_r <= entry_r[cfg.rd_pad];
        end
    end

    assign cfg.rd_data = rd_r;
    assign cfg.table_q = entry_r;
endmodule // pad_cfg_store
`default_nettype wire

// *** rtl/io_pad_group_mux.sv ***
// Purpose: routes peripheral signals to and from the configurable pads
// Assumes: pad p sits in group p mod 4; package strap steady around reset
// Notes:   one entry per pad: enable, direction, selector within its group
// Functional notes
// - group 0 inputs: debug, lanes 0/4, sclk, gpio
// - group 0 outputs: debug, serial, lanes, pwm, host, gpio
// - group 1 inputs: serial rx, lanes 1/5, din, gpio
// - group 1 outputs: lanes, pwm, din, host dout, gpio
// - group 2 inputs: carrier, lanes 2/6, strobe, gpio
// - group 2 outputs: rts, lanes, pwm, slave dout, gpio
// - group 3 inputs: cts, ring, lanes, selects, gpio
// - group 3 outputs: lanes 3/7, pwm, host select, gpio
// - pad is one input or one output, own group
// - adjacent pads cover all four groups
// - pad count 12, 28 or 44 by package
// - pads take a defined default after reset
`include "io_pad_group_map.svh"
`default_nettype none
module io_pad_group_mux
    import io_pad_group_pkg::*;
(
    input  wire logic                  clk_sys_in,
    input  wire logic                  reset_n_in,
    input  wire logic [1:0]            pkg_sel_in,
    input  wire logic                  cfg_wr_in,
    input  wire logic [`PAD_IDX_W-1:0] cfg_pad_in,
    input  wire logic                  cfg_en_in,
    input  wire logic                  cfg_dir_in,
    input  wire logic [`SEL_W-1:0]     cfg_sel_in,
    output logic                       cfg_ack_out,
    output logic                       cfg_err_out,
    input  wire logic [`PAD_IDX_W-1:0] cfg_rd_pad_in,
    output logic                       cfg_rd_en_out,
    output logic                       cfg_rd_dir_out,
    output logic [`SEL_W-1:0]          cfg_rd_sel_out,
    output logic [`PAD_IDX_W-1:0]      pad_count_out,
    input  wire logic [`POUT_W-1:0]    periph_out_in,
    output logic [`PIN_W-1:0]          periph_in_out,
    input  wire logic [`NUM_PADS-1:0]  pad_in,
    output logic [`NUM_PADS-1:0]       pad_out,
    output logic [`NUM_PADS-1:0]       pad_oe_n_out
);
    pad_cfg_if cfg ();

    pad_cfg_store u_store (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .cfg        (cfg.store)
    );

    function automatic route_s pad_route(input logic [`GROUP_W-1:0] grp,
                                         input logic dir,
                                         input logic [`SEL_W-1:0] sel);
        route_s            r;
        logic [`SEL_W-1:0] nfix;
        logic [`SEL_W-1:0] j;
        logic [`SEL_W-1:0] ngpio;
        logic              skip;
        logic [2:0]        lane;
        logic [2:0]        hi;
        r     = '0;
        lane  = {1'b0, grp};
        hi    = lane + `HALF_STEP;
        skip  = (dir == `DIR_OUT && grp == 2'h2) || (dir == `DIR_IN && grp == 2'h3);
        ngpio = (skip || (dir == `DIR_OUT && grp == 2'h3)) ? `GPIO_SHORT_CNT : `GPIO_FULL_CNT;
        if (dir == `DIR_OUT) begin
            unique case (grp)
                2'h0: nfix = 5'd11;
                2'h1: nfix = 5'd9;
                2'h2: nfix = 5'd7;
                2'h3: nfix = 5'd5;
            endcase
        end else begin
            unique case (grp)
                2'h0: nfix = 5'd6;
                2'h1: nfix = 5'd6;
                2'h2: nfix = 5'd5;
                2'h3: nfix = 5'd7;
            endcase
        end
        if (sel < nfix) begin
            r.ok = 1'b1;
            // byte lane and pwm entries follow the group number and the group number plus four
            if (sel == 5'd1)
                r.idx = (dir == `DIR_OUT) ? `PAR_OUT_BASE + {4'h0, lane} : `PAR_IN_BASE + {4'h0, lane};
            else if (sel == 5'd2)
                r.idx = (dir == `DIR_OUT) ? `PAR_OUT_BASE + {4'h0, hi} : `PAR_IN_BASE + {4'h0, hi};
            else if (dir == `DIR_OUT && sel == 5'd3)
                r.idx = `PWM_BASE + {4'h0, lane};
            else if (dir == `DIR_OUT && sel == 5'd4)
                r.idx = `PWM_BASE + {4'h0, hi};
            else begin
                unique case ({dir, grp})
                    3'b100: r.idx = (sel == 5'd0) ? `O_DBG : (sel == 5'd5) ? `O_SER_TX :
                                    (sel == 5'd6) ? `O_SER_TRDY_N : (sel == 5'd7) ? `O_SER_DRV_EN :
                                    (sel == 5'd8) ? `O_PAR_RXAV_N : (sel == 5'd9) ? `O_HOST_SCLK : `O_HOST_SEL1_N;
                    3'b101: r.idx = (sel == 5'd0) ? `O_PAR_TXSP_N : (sel == 5'd5) ? `O_SLV0_DIN :
                                    (sel == 5'd6) ? `O_SLV1_DIN : (sel == 5'd7) ? `O_HOST_DOUT : `O_PAR_SYNC_CLK;
                    3'b110: r.idx = (sel == 5'd0) ? `O_SER_RTS_N : (sel == 5'd5) ? `O_SLV0_DOUT : `O_SLV1_DOUT;
                    3'b111: r.idx = `O_HOST_SEL0_N;
                    3'b000: r.idx = (sel == 5'd0) ? `I_DBG : (sel == 5'd3) ? `I_PAR_OE_N :
                                    (sel == 5'd4) ? `I_SLV0_SCLK : `I_SLV1_SCLK;
                    3'b001: r.idx = (sel == 5'd0) ? `I_SER_RX : (sel == 5'd3) ? `I_SER_SRDY_N :
                                    (sel == 5'd4) ? `I_SLV0_DIN : `I_SLV1_DIN;
                    3'b010: r.idx = (sel == 5'd0) ? `I_SER_CARR_N : (sel == 5'd3) ? `I_PAR_RD_N : `I_HOST_DIN;
                    3'b011: r.idx = (sel == 5'd0) ? `I_SER_CTS_N : (sel == 5'd3) ? `I_SER_RING_N :
                                    (sel == 5'd4) ? `I_PAR_WR_N : (sel == 5'd5) ? `I_SLV0_SEL_N : `I_SLV1_SEL_N;
                endcase
            end
        end else if ((sel - nfix) < ngpio) begin
            j = sel - nfix;
            if (skip && j >= `GPIO_SKIP_POS)
                j = j + 5'd1;
            // gpio port letter is j/2, bit is the lane or lane plus four
            r.ok  = 1'b1;
            r.idx = {1'b0, j[3:1], (j[0] ? hi : lane)};
        end
        return r;
    endfunction

    // strap capture: taken at the first edge after reset release, never under reset
    logic                  strap_done_r;
    logic [`PAD_IDX_W-1:0] pad_count_r;

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_done_r <= 1'b0;
            pad_count_r  <= `PADS_64PIN;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            pad_count_r  <= pads_for_pkg(pkg_sel_in);
        end
    end

    // pad inputs come from outside: three stages, value moves once stages two and three agree
    logic [`NUM_PADS-1:0] sync1_r;
    logic [`NUM_PADS-1:0] sync2_r;
    logic [`NUM_PADS-1:0] sync3_r;
    logic [`NUM_PADS-1:0] pad_filt_r;
    logic [`NUM_PADS-1:0] stage_agree;

    assign stage_agree = ~(sync2_r ^ sync3_r);

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync1_r    <= '0;
            sync2_r    <= '0;
            sync3_r    <= '0;
            pad_filt_r <= '0;
        end else begin
            sync1_r    <= pad_in;
            sync2_r    <= sync1_r;
            sync3_r    <= sync2_r;
            pad_filt_r <= (stage_agree & sync3_r) | (~stage_agree & pad_filt_r);
        end
    end

    // configuration write: an enabled entry is accepted only if its selector lies in the pad's own group list
    logic [`GROUP_W-1:0] wr_group;
    route_s              wr_route;
    logic                wr_pad_ok;
    logic                wr_legal;

    assign wr_group  = cfg_pad_in[`GROUP_W-1:0];
    assign wr_route  = pad_route(wr_group, cfg_dir_in, cfg_sel_in);
    assign wr_pad_ok = cfg_pad_in < pad_count_r;
    assign wr_legal  = wr_pad_ok && (!cfg_en_in || wr_route.ok);

    assign cfg.wr          = cfg_wr_in && wr_legal;
    assign cfg.wr_pad      = cfg_pad_in;
    assign cfg.wr_data.en  = cfg_en_in;
    assign cfg.wr_data.dir = cfg_dir_in;
    assign cfg.wr_data.sel = cfg_sel_in;
    assign cfg.rd_pad      = cfg_rd_pad_in;

    logic ack_r;
    logic err_r;

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            ack_r <= cfg_wr_in && wr_legal;
            err_r <= cfg_wr_in && !wr_legal;
        end
    end

    // per-pad route decode; the group is the low two bits of the pad number
    route_s               pad_rt    [`NUM_PADS];
    logic [`NUM_PADS-1:0] pad_live;
    logic [`NUM_PADS-1:0] pad_is_out;
    logic [`NUM_PADS-1:0] pad_is_in;
    logic [`NUM_PADS-1:0] pad_drive;

    for (genvar p = 0; p < `NUM_PADS; p++) begin : g_pad
        localparam logic [`PAD_IDX_W-1:0] PAD_NUM = `PAD_IDX_W'(p);
        assign pad_rt[p]     = pad_route(PAD_NUM[`GROUP_W-1:0], cfg.table_q[p].dir,
                                         cfg.table_q[p].sel);
        assign pad_live[p]   = cfg.table_q[p].en && pad_rt[p].ok && (PAD_NUM < pad_count_r);
        assign pad_is_out[p] = pad_live[p] && (cfg.table_q[p].dir == `DIR_OUT);
        assign pad_is_in[p]  = pad_live[p] && (cfg.table_q[p].dir == `DIR_IN);
        assign pad_drive[p]  = periph_out_in[pad_rt[p].idx];
    end

    // input gather: lowest numbered pad wins when two pads feed one peripheral input
    logic [`PIN_W-1:0] pin_nxt;

    always_comb begin
        pin_nxt = `PIN_IDLE;
        for (int p = `NUM_PADS - 1; p >= 0; p--) begin
            if (pad_is_in[p])
                pin_nxt[pad_rt[p].idx[`PAD_IDX_W-1:0]] = pad_filt_r[p];
        end
    end

    // outputs registered so a reconfiguration never glitches a pad
    logic [`NUM_PADS-1:0] pad_out_r;
    logic [`NUM_PADS-1:0] pad_oe_n_r;
    logic [`PIN_W-1:0]    pin_r;

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pad_out_r  <= '0;
            pad_oe_n_r <= '1;
            pin_r      <= `PIN_IDLE;
        end else begin
            pad_out_r  <= pad_drive & pad_is_out;
            pad_oe_n_r <= ~pad_is_out;
            pin_r      <= pin_nxt;
        end
    end

    assign pad_out        = pad_out_r;
    assign pad_oe_n_out   = pad_oe_n_r;
    assign periph_in_out  = pin_r;
    assign pad_count_out  = pad_count_r;
    assign cfg_ack_out    = ack_r;
    assign cfg_err_out    = err_r;
    assign cfg_rd_en_out  = cfg.rd_data.en;
    assign cfg_rd_dir_out = cfg.rd_data.dir;
    assign cfg_rd_sel_out = cfg.rd_data.sel;

endmodule // io_pad_group_mux
`default_nettype wire

// *** test/io_pad_group_mux_assertions.sv ***
// Purpose: concurrent checks on the pad group mux ports
// Assumes: bound to the top module, single clock domain
// Notes:   selector limits are the list lengths per group and direction
`include "io_pad_group_map.svh"
`default_nettype none
module io_pad_group_mux_chk (
    input wire logic                  clk_sys_in,
    input wire logic                  reset_n_in,
    input wire logic                  cfg_wr_in,
    input wire logic [`PAD_IDX_W-1:0] cfg_pad_in,
    input wire logic                  cfg_en_in,
    input wire logic                  cfg_dir_in,
    input wire logic [`SEL_W-1:0]     cfg_sel_in,
    input wire logic                  cfg_ack_out,
    input wire logic                  cfg_err_out,
    input wire logic [`PAD_IDX_W-1:0] pad_count_out,
    input wire logic [`PIN_W-1:0]     periph_in_out,
    input wire logic [`NUM_PADS-1:0]  pad_out,
    input wire logic [`NUM_PADS-1:0]  pad_oe_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0]           sel_lim;
    logic [`NUM_PADS-1:0] beyond;
    logic [1:0]           grp;
    assign grp = cfg_pad_in[1:0];
    assign sel_lim = cfg_dir_in ? (grp == 2'h0 ? 5'h15 : grp == 2'h1 ? 5'h13 : grp == 2'h2 ? 5'h10 : 5'h0e)
                                : (grp == 2'h2 ? 5'h0f : 5'h10);
    always_comb
        for (int p = 0; p < `NUM_PADS; p++)
            beyond[p] = (p >= pad_count_out);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    chk_one_answer: assert property (cfg_wr_in |=> cfg_ack_out ^ cfg_err_out)
        else $error("write not answered by exactly one of ack and err");
    chk_quiet_idle: assert property (!cfg_wr_in |=> !cfg_ack_out && !cfg_err_out)
        else $error("answer without a write");
    chk_pad_range: assert property (cfg_wr_in && cfg_pad_in >= pad_count_out |=> cfg_err_out)
        else $error("write beyond pad count accepted");
    chk_sel_range: assert property (cfg_wr_in && cfg_en_in && cfg_sel_in >= sel_lim |=> cfg_err_out)
        else $error("selector outside group list accepted");
    chk_good_write: assert property (cfg_wr_in && cfg_pad_in < pad_count_out &&
        (!cfg_en_in || cfg_sel_in < sel_lim) |=> cfg_ack_out) else $error("legal write refused");
    chk_beyond_off: assert property (&(pad_oe_n_out | ~beyond))
        else $error("pad beyond count driven");
    chk_idle_low: assert property (~|(pad_out & pad_oe_n_out))
        else $error("undriven pad shows a one");
    chk_reset_out: assert property (!$past(reset_n_in) |-> &pad_oe_n_out && periph_in_out == `PIN_IDLE)
        else $error("outputs not at default after reset");
    chk_count_legal: assert property (pad_count_out inside {6'h0c, 6'h1c, 6'h2c})
        else $error("pad count not a package value");
    chk_count_held: assert property ($past(reset_n_in, 2) |-> $stable(pad_count_out))
        else $error("pad count changed outside reset");
    cov_ack: cover property (cfg_ack_out);
    cov_err: cover property (cfg_err_out);
    cov_drive: cover property (~&pad_oe_n_out);
endmodule // io_pad_group_mux_chk
bind io_pad_group_mux io_pad_group_mux_chk i_chk (.clk_sys_in, .reset_n_in, .cfg_wr_in, .cfg_pad_in, .cfg_en_in,
    .cfg_dir_in, .cfg_sel_in, .cfg_ack_out, .cfg_err_out, .pad_count_out, .periph_in_out, .pad_out, .pad_oe_n_out);
`default_nettype wire

// *** test/io_pad_far_model.sv ***
// Purpose: pad side of the mux: board drivers and floating lines
// Assumes: bench decides which pads the board drives
// Notes:   a floating pad shows the inverse of its last level
`include "io_pad_group_map.svh"
`default_nettype none
module io_pad_far_model (
    input  wire logic                 clk_sys_in,
    input  wire logic                 reset_n_in,
    input  wire logic [`NUM_PADS-1:0] dev_val_in,
    input  wire logic [`NUM_PADS-1:0] dev_oe_n_in,
    input  wire logic [`NUM_PADS-1:0] ext_val_in,
    input  wire logic [`NUM_PADS-1:0] ext_oe_in,
    output logic      [`NUM_PADS-1:0] pad_level_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [`NUM_PADS-1:0] last_r;
    logic [`NUM_PADS-1:0] driven;
    // no pull on the pads, so a released pad flips to the inverse of its last driven level
    assign driven        = ~dev_oe_n_in | ext_oe_in;
    assign pad_level_out = (~dev_oe_n_in & dev_val_in) | (dev_oe_n_in & ext_oe_in & ext_val_in)
                         | (~driven & ~last_r);
    always_ff @(posedge clk_sys_in)
        last_r <= reset_n_in ? ((driven & pad_level_out) | (~driven & last_r)) : '0;
endmodule // io_pad_far_model
`default_nettype wire

// *** test/io_pad_group_mux_bench.sv ***
// Purpose: self-checking bench of the pad group mux
// Assumes: inputs change on the falling edge and outputs are read there
// Notes:   every selector of every group is routed once in its direction
`include "io_pad_group_map.svh"
`default_nettype none
module io_pad_group_mux_bench
    import io_pad_group_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] IDLE = `PIN_IDLE;
    // index 0..3 inputs of groups 0..3, 4..7 outputs
    localparam int NFIX[8] = '{6, 6, 5, 7, 11, 9, 7, 5};
    localparam int OFFS[8] = '{32, 38, 44, 49, 0, 11, 20, 27};
    localparam int NGP[8]  = '{10, 10, 10, 9, 10, 10, 9, 9};
    localparam logic [6:0] FIX[56] = '{7'h38, 7'h30, 7'h34, 7'h28, 7'h2c, 7'h39, 7'h3a, 7'h3b, 7'h3c, 7'h3d,
        7'h3e, 7'h3f, 7'h31, 7'h35, 7'h29, 7'h2d, 7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h32, 7'h36, 7'h2a,
        7'h2e, 7'h45, 7'h46, 7'h47, 7'h33, 7'h37, 7'h2b, 7'h2f, 7'h30, 7'h28, 7'h2c, 7'h31, 7'h32, 7'h33,
        7'h34, 7'h29, 7'h2d, 7'h35, 7'h36, 7'h37, 7'h38, 7'h2a, 7'h2e, 7'h39, 7'h3a, 7'h3b, 7'h2b, 7'h2f,
        7'h3c, 7'h3d, 7'h3e, 7'h3f};
    logic                  clk_sys_in, reset_n_in, cfg_wr_in, cfg_en_in, cfg_dir_in;
    logic                  cfg_ack_out, cfg_err_out, cfg_rd_en_out, cfg_rd_dir_out;
    logic [1:0]            pkg_sel_in;
    logic [`PAD_IDX_W-1:0] cfg_pad_in, cfg_rd_pad_in, pad_count_out;
    logic [`SEL_W-1:0]     cfg_sel_in, cfg_rd_sel_out;
    logic [`POUT_W-1:0]    periph_out_in;
    logic [`PIN_W-1:0]     periph_in_out;
    logic [`NUM_PADS-1:0]  pad_in, pad_out, pad_oe_n_out, ext_val, ext_oe;
    int                    fails, n_compared, cycles;

    io_pad_group_mux i_dut (.clk_sys_in, .reset_n_in, .pkg_sel_in, .cfg_wr_in, .cfg_pad_in, .cfg_en_in,
        .cfg_dir_in, .cfg_sel_in, .cfg_ack_out, .cfg_err_out, .cfg_rd_pad_in, .cfg_rd_en_out, .cfg_rd_dir_out,
        .cfg_rd_sel_out, .pad_count_out, .periph_out_in, .periph_in_out, .pad_in, .pad_out, .pad_oe_n_out);
    io_pad_far_model i_far (.clk_sys_in, .reset_n_in, .dev_val_in(pad_out), .dev_oe_n_in(pad_oe_n_out),
        .ext_val_in(ext_val), .ext_oe_in(ext_oe), .pad_level_out(pad_in));

    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            $display("mismatch at %0t: run did not finish", $time);
            stop_test();
        end
    end

    task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic cfg_write(input int pad, input logic en, input logic dir, input int sel, input logic ok);
        cfg_wr_in = 1'b1;
        cfg_pad_in = 6'(pad);
        cfg_en_in = en;
        cfg_dir_in = dir;
        cfg_sel_in = 5'(sel);
        @(negedge clk_sys_in);
        cfg_wr_in = 1'b0;
        check({cfg_ack_out, cfg_err_out}, {ok, !ok}, "write answer");
        @(negedge clk_sys_in);
    endtask

    function automatic logic [6:0] exp_idx(input int k, input int s);
        int j;
        j = s - NFIX[k];
        if (j < 0)
            return FIX[OFFS[k] + s];
        if ((k == 3 || k == 6) && j >= 3)
            j = j + 1;
        return 7'((j / 2) * 8 + (j % 2) * 4 + k % 4);
    endfunction

    task automatic route_case(input int k, input int s);
        int         pad;
        logic       dir;
        logic [6:0] idx;
        logic       lvl;
        pad = k % 4 + 4 * (s % 11);
        dir = (k >= 4);
        idx = exp_idx(k, s);
        cfg_write(pad, 1'b1, dir, s, 1'b1);
        cfg_rd_pad_in = 6'(pad);
        for (int v = 0; v < 2; v++) begin
            if (dir) begin
                periph_out_in = v[0] ? (72'h1 << idx) : ~(72'h1 << idx);
                repeat (2) @(negedge clk_sys_in);
                check({pad_oe_n_out[pad], pad_out[pad]}, {1'b0, v[0]}, "pad drive");
            end else begin
                lvl = IDLE[idx[5:0]] ^ !v[0];
                ext_oe[pad] = 1'b1;
                ext_val[pad] = lvl;
                repeat (6) @(negedge clk_sys_in);
                check(periph_in_out[idx[5:0]], lvl, "peripheral input");
            end
        end
        check({cfg_rd_en_out, cfg_rd_dir_out, cfg_rd_sel_out}, {1'b1, dir, 5'(s)}, "readback");
        cfg_write(pad, 1'b0, dir, s, 1'b1);
        ext_oe[pad] = 1'b0;
        repeat (6) @(negedge clk_sys_in);
        check({pad_oe_n_out[pad], periph_in_out}, {1'b1, IDLE}, "pad released");
    endtask

    task automatic adjacent_case();
        cfg_write(8, 1'b1, 1'b1, 5, 1'b1);
        cfg_write(9, 1'b1, 1'b0, 0, 1'b1);
        cfg_write(10, 1'b1, 1'b1, 0, 1'b1);
        cfg_write(11, 1'b1, 1'b0, 0, 1'b1);
        periph_out_in = (72'h1 << 57) | (72'h1 << 68);
        ext_oe = 44'h0000000a00;
        ext_val = 44'h0000000200;
        repeat (6) @(negedge clk_sys_in);
        check({pad_out[8], pad_out[10], periph_in_out[52], periph_in_out[59]}, 4'he, "serial on four pads");
        for (int p = 8; p < 12; p++)
            cfg_write(p, 1'b0, 1'b0, 0, 1'b1);
        ext_oe = '0;
    endtask

    task automatic refuse_case();
        cfg_write(5, 1'b1, 1'b0, 0, 1'b1);
        for (int k = 0; k < 8; k++)
            cfg_write(k % 4 + 4, 1'b1, k >= 4, NFIX[k] + NGP[k], 1'b0);
        cfg_write(44, 1'b1, 1'b1, 0, 1'b0);
        cfg_rd_pad_in = 6'h05;
        repeat (2) @(negedge clk_sys_in);
        check({cfg_rd_en_out, cfg_rd_dir_out, cfg_rd_sel_out}, 7'h40, "entry kept after refusal");
        cfg_write(5, 1'b0, 1'b0, 0, 1'b1);
    endtask

    task automatic do_reset(input logic [1:0] pkg, input logic [5:0] cnt);
        reset_n_in = 1'b0;
        pkg_sel_in = pkg;
        repeat (16) @(negedge clk_sys_in);
        check({pad_oe_n_out, pad_out}, {{`NUM_PADS{1'b1}}, {`NUM_PADS{1'b0}}}, "pads in reset");
        check(periph_in_out, IDLE, "inputs in reset");
        reset_n_in = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        check(pad_count_out, cnt, "pad count");
    endtask

    initial begin
        cfg_wr_in = 1'b0;
        cfg_pad_in = '0;
        cfg_en_in = 1'b0;
        cfg_dir_in = 1'b0;
        cfg_sel_in = '0;
        cfg_rd_pad_in = '0;
        periph_out_in = '0;
        ext_val = '0;
        ext_oe = '0;
        do_reset(2'h2, 6'h2c);
        for (int k = 0; k < 8; k++)
            for (int s = 0; s < NFIX[k] + NGP[k]; s++)
                route_case(k, s);
        adjacent_case();
        refuse_case();
        do_reset(2'h0, 6'h0c);
        cfg_write(12, 1'b1, 1'b1, 0, 1'b0);
        cfg_write(11, 1'b1, 1'b1, 0, 1'b1);
        check(pad_oe_n_out[11], 1'b0, "last pad of small package drives");
        do_reset(2'h1, 6'h1c);
        cfg_write(28, 1'b1, 1'b1, 0, 1'b0);
        cfg_write(27, 1'b1, 1'b1, 0, 1'b1);
        check(pad_oe_n_out[27], 1'b0, "last pad of mid package drives");
        do_reset(2'h3, 6'h2c);
        pkg_sel_in = 2'h0;
        repeat (2) @(negedge clk_sys_in);
        check(pad_count_out, 6'h2c, "strap ignored after capture");
        stop_test();
    end
endmodule // io_pad_group_mux_bench
`default_nettype wire
